// file: hw/mtch_pkg.sv
// Constants for the multi-trigger capture handshake.
// Assumes a single 10 MHz system clock.
package mtch_pkg;
   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned SEC_S          = 1;
   localparam int unsigned SEC_CYC        = CLK_HZ * SEC_S;
   localparam logic [5:0]  TIMEOUT_MIN_S  = 6'h01;
   localparam logic [5:0]  TIMEOUT_MAX_S  = 6'h3C;
   localparam logic [5:0]  TIMEOUT_DEF_S  = 6'h0A;
   // ==========================================================
   // Sizes
   localparam int unsigned TASK_W         = 4;
   // ==========================================================
   // Sequencer states
   typedef enum logic [2:0] {
      MTCH_IDLE      = 3'b000,
      MTCH_CAPTURE   = 3'b001,
      MTCH_WAIT_TRIG = 3'b010,
      MTCH_WAIT_MEAS = 3'b011,
      MTCH_DRAIN     = 3'b100,
      MTCH_POST      = 3'b101
   } mtch_state_t;
endpackage

// file: hw/mtch_meas_if.sv
// Link between the sequencer and the measurement scheduler.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface mtch_meas_if #(parameter int W = 4);
   logic           clear;
   logic           serial;
   logic           cap_evt;
   logic           meas_done;
   logic           meas_start;
   logic [W-1:0]   meas_id;
   logic [W:0]     done_cnt;
   logic           drained;
   modport sched (input clear, input serial, input cap_evt, input meas_done,
                  output meas_start, output meas_id, output done_cnt, output drained);
   modport ctrl  (output clear, output serial, output cap_evt, output meas_done,
                  input meas_start, input meas_id, input done_cnt, input drained);
endinterface

// file: hw/mtch_meas.sv
// Measurement scheduler: launches one measurement per captured image.
// Assumes the measurement engine pulses meas_done once per launch.
`timescale 1ns/1ps
module mtch_meas #(
   parameter int W = mtch_pkg::TASK_W
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Sequencer side
   mtch_meas_if.sched       m
);
   logic [W:0] cap_cnt;
   logic [W:0] iss_cnt;
   logic       can_issue;

   // ==========================================================
   // Launch control
   // Serial mode waits for every earlier measurement to finish
   assign can_issue = (iss_cnt < cap_cnt) && (!m.serial || (m.done_cnt == iss_cnt));

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         m.meas_start <= 1'b0;
         m.meas_id    <= '0;
         iss_cnt      <= '0;
      end
      else if (m.clear)
      begin
         m.meas_start <= 1'b0;
         iss_cnt      <= '0;
      end
      else if (can_issue && !m.meas_start)
      begin
         m.meas_start <= 1'b1;
         m.meas_id    <= iss_cnt[W-1:0];
         iss_cnt      <= iss_cnt + 1'b1;
      end
      else
         m.meas_start <= 1'b0;
   end

   // ==========================================================
   // Counters
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         cap_cnt <= '0;
      else if (m.clear)
         cap_cnt <= '0;
      else if (m.cap_evt)
         cap_cnt <= cap_cnt + 1'b1;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         m.done_cnt <= '0;
      else if (m.clear)
         m.done_cnt <= '0;
      else if (m.meas_done)
         m.done_cnt <= m.done_cnt + 1'b1;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         m.drained <= 1'b1;
      else
         m.drained <= !m.clear && !m.cap_evt && (m.done_cnt == cap_cnt) && (iss_cnt == cap_cnt);
   end

   // ==========================================================
   // Checks
   property p_serial_gap;
      @(posedge clk) disable iff (!resetn)
      (m.meas_start && m.serial) |-> (m.done_cnt + 1'b1 == iss_cnt);
   endproperty
   a_serial_gap: assert property (p_serial_gap) else $error("Serial launch overlapped a running measurement");
endmodule

// file: hw/mtch_top.sv
// Multi-trigger capture handshake: trigger, ready and busy towards the host,
// capture, measurement and post-processing strobes towards the pipeline.
// Assumes all inputs except trigger are synchronous to clk; done strobes are one-cycle pulses.
//
// Behaviour
// - First trigger drops ready, raises busy, starts the first capture.
// - Shared settings: ready rises once the capture completes; measurement follows.
// - Each later trigger drops ready while busy stays high.
// - Shared settings: ready stays low after the final capture.
// - Serial execution: next measurement waits for the previous one.
// - Busy drops when all measurement and post processing are finished.
// - Per-capture concurrent: ready rises after a capture completes.
// - Per-capture: each capture uses its own task's camera settings.
// - Per-capture: after final capture, ready rises only when measurement completes.
// - Shared settings: ready high and busy low together at the end.
// - Per-capture serial: ready waits for the whole task block.
// - Post processing runs only after every task block completes.
// - No trigger within timeout after ready rises fails the sequence.
// - Shared settings: every capture uses the first task's camera settings.
`timescale 1ns/1ps
module mtch_top #(
   parameter int          TASK_W      = mtch_pkg::TASK_W,
   parameter int unsigned CYC_PER_SEC = mtch_pkg::SEC_CYC
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // Configuration
   input  wire logic              shared_settings,
   input  wire logic              concurrent,
   input  wire logic [TASK_W-1:0] num_tasks,
   input  wire logic [5:0]        timeout_sec,
   // Host handshake
   input  wire logic              trigger,
   output logic                   ready,
   output logic                   busy,
   output logic                   seq_ng,
   // Capture unit
   output logic                   cap_start,
   output logic [TASK_W-1:0]      cap_sel,
   input  wire logic              cap_done,
   // Measurement engine
   output logic                   meas_start,
   output logic [TASK_W-1:0]      meas_id,
   input  wire logic              meas_done,
   // Post processing
   output logic                   post_start,
   input  wire logic              post_done
);
   mtch_pkg::mtch_state_t state;
   logic [TASK_W-1:0] cur;
   logic [TASK_W-1:0] last_idx;
   logic              cfg_shared;
   logic              cfg_conc;
   logic [5:0]        cfg_tmo;
   logic              trig_s1;
   logic              trig_s2;
   logic              trig_d;
   logic              trig_rise;
   logic              trig_acc;
   logic              last;
   logic [31:0]       tick_cnt;
   logic [5:0]        sec_cnt;
   logic              tmo_hit;
   logic [5:0]        tmo_eff;

   mtch_meas_if #(.W(TASK_W)) m ();

   mtch_meas #(.W(TASK_W)) u_meas (
      .clk    (clk),
      .resetn (resetn),
      .m      (m.sched)
   );

   assign m.meas_done = meas_done;
   assign meas_start  = m.meas_start;
   assign meas_id     = m.meas_id;

   // ==========================================================
   // Trigger synchroniser and edge detect
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_d  <= 1'b0;
      end
      else
      begin
         trig_s1 <= trigger;
         trig_s2 <= trig_s1;
         trig_d  <= trig_s2;
      end
   end

   assign trig_rise = trig_s2 && !trig_d;
   // Edges outside the waiting states are dropped, never queued
   assign trig_acc  = trig_rise && ready &&
                      ((state == mtch_pkg::MTCH_IDLE) || (state == mtch_pkg::MTCH_WAIT_TRIG));
   assign last      = (cur == last_idx);

   // Clamp out-of-range settings rather than reject them
   assign tmo_eff = (timeout_sec < mtch_pkg::TIMEOUT_MIN_S) ? mtch_pkg::TIMEOUT_MIN_S :
                    (timeout_sec > mtch_pkg::TIMEOUT_MAX_S) ? mtch_pkg::TIMEOUT_MAX_S : timeout_sec;

   // ==========================================================
   // Timeout between tasks, whole seconds from ready rising
   assign tmo_hit = (state == mtch_pkg::MTCH_WAIT_TRIG) && (sec_cnt >= cfg_tmo) && !trig_acc;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tick_cnt <= '0;
         sec_cnt  <= '0;
      end
      else if (state != mtch_pkg::MTCH_WAIT_TRIG)
      begin
         tick_cnt <= '0;
         sec_cnt  <= '0;
      end
      else if (tick_cnt == CYC_PER_SEC - 1)
      begin
         tick_cnt <= '0;
         sec_cnt  <= sec_cnt + 1'b1;
      end
      else
         tick_cnt <= tick_cnt + 1'b1;
   end

   // ==========================================================
   // Configuration latched at sequence start
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cfg_shared <= 1'b1;
         cfg_conc   <= 1'b1;
         cfg_tmo    <= mtch_pkg::TIMEOUT_DEF_S;
         last_idx   <= '0;
      end
      else if (trig_acc && (state == mtch_pkg::MTCH_IDLE))
      begin
         cfg_shared <= shared_settings;
         cfg_conc   <= concurrent;
         cfg_tmo    <= tmo_eff;
         last_idx   <= (num_tasks == '0) ? '0 : num_tasks - 1'b1;
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state      <= mtch_pkg::MTCH_IDLE;
         ready      <= 1'b1;
         busy       <= 1'b0;
         seq_ng     <= 1'b0;
         cur        <= '0;
         cap_start  <= 1'b0;
         cap_sel    <= '0;
         post_start <= 1'b0;
         m.clear    <= 1'b0;
         m.serial   <= 1'b0;
         m.cap_evt  <= 1'b0;
      end
      else
      begin
         cap_start  <= 1'b0;
         post_start <= 1'b0;
         m.clear    <= 1'b0;
         m.cap_evt  <= 1'b0;
         unique case (state)
            mtch_pkg::MTCH_IDLE:
            begin
               if (trig_acc)
               begin
                  ready     <= 1'b0;
                  busy      <= 1'b1;
                  seq_ng    <= 1'b0;
                  cur       <= '0;
                  cap_start <= 1'b1;
                  cap_sel   <= '0;
                  m.clear   <= 1'b1;
                  m.serial  <= !concurrent;
                  state     <= mtch_pkg::MTCH_CAPTURE;
               end
            end
            mtch_pkg::MTCH_CAPTURE:
            begin
               if (cap_done)
               begin
                  m.cap_evt <= 1'b1;
                  if (cfg_shared)
                  begin
                     ready <= !last;
                     state <= last ? mtch_pkg::MTCH_DRAIN : mtch_pkg::MTCH_WAIT_TRIG;
                  end
                  else if (cfg_conc && !last)
                  begin
                     ready <= 1'b1;
                     state <= mtch_pkg::MTCH_WAIT_TRIG;
                  end
                  else
                     state <= mtch_pkg::MTCH_WAIT_MEAS;
               end
            end
            mtch_pkg::MTCH_WAIT_MEAS:
            begin
               // Counter is one behind for a cycle after cap_evt, so this cannot fire early
               if (m.done_cnt == {1'b0, cur} + 1'b1)
               begin
                  ready <= 1'b1;
                  state <= last ? mtch_pkg::MTCH_DRAIN : mtch_pkg::MTCH_WAIT_TRIG;
               end
            end
            mtch_pkg::MTCH_WAIT_TRIG:
            begin
               if (trig_acc)
               begin
                  ready     <= 1'b0;
                  cur       <= cur + 1'b1;
                  cap_start <= 1'b1;
                  cap_sel   <= cfg_shared ? '0 : cur + 1'b1;
                  state     <= mtch_pkg::MTCH_CAPTURE;
               end
               else if (tmo_hit)
               begin
                  seq_ng <= 1'b1;
                  ready  <= 1'b0;
                  state  <= mtch_pkg::MTCH_DRAIN;
               end
            end
            mtch_pkg::MTCH_DRAIN:
            begin
               // A failed sequence still lets running measurements finish, but skips post processing
               if (m.drained && !m.cap_evt)
               begin
                  if (seq_ng)
                  begin
                     busy  <= 1'b0;
                     ready <= 1'b1;
                     state <= mtch_pkg::MTCH_IDLE;
                  end
                  else
                  begin
                     post_start <= 1'b1;
                     state      <= mtch_pkg::MTCH_POST;
                  end
               end
            end
            mtch_pkg::MTCH_POST:
            begin
               if (post_done)
               begin
                  busy  <= 1'b0;
                  ready <= 1'b1;
                  state <= mtch_pkg::MTCH_IDLE;
               end
            end
            default:
               state <= mtch_pkg::MTCH_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Checks
   property p_first_trig;
      @(posedge clk) disable iff (!resetn)
      (trig_acc && state == mtch_pkg::MTCH_IDLE) |=> (!ready && busy && cap_start);
   endproperty
   a_first_trig: assert property (p_first_trig) else $error("First trigger did not start the sequence");
   property p_shared_ready;
      @(posedge clk) disable iff (!resetn)
      (state == mtch_pkg::MTCH_CAPTURE && cap_done && cfg_shared && !last) |=> ready;
   endproperty
   a_shared_ready: assert property (p_shared_ready) else $error("Ready not raised after shared capture");
   property p_later_trig;
      @(posedge clk) disable iff (!resetn)
      (state == mtch_pkg::MTCH_WAIT_TRIG && trig_acc) |=> (!ready && busy && cap_start);
   endproperty
   a_later_trig: assert property (p_later_trig) else $error("Later trigger handled wrongly");
   property p_shared_last;
      @(posedge clk) disable iff (!resetn)
      (state == mtch_pkg::MTCH_CAPTURE && cap_done && cfg_shared && last) |=> !ready [*2];
   endproperty
   a_shared_last: assert property (p_shared_last) else $error("Ready rose after final shared capture");
   property p_per_hold;
      @(posedge clk) disable iff (!resetn)
      (state == mtch_pkg::MTCH_CAPTURE && cap_done && !cfg_shared && (last || !cfg_conc))
         |=> (!ready until (m.done_cnt == {1'b0, cur} + 1'b1));
   endproperty
   a_per_hold: assert property (p_per_hold) else $error("Ready rose before task measurement");
   property p_end;
      @(posedge clk) disable iff (!resetn)
      (state == mtch_pkg::MTCH_POST && post_done) |=> (ready && !busy);
   endproperty
   a_end: assert property (p_end) else $error("Ready and busy not released together");
   property p_busy_post;
      @(posedge clk) disable iff (!resetn)
      $fell(busy) |-> (seq_ng || $past(post_done));
   endproperty
   a_busy_post: assert property (p_busy_post) else $error("Busy dropped before post processing ended");
   property p_post_gate;
      @(posedge clk) disable iff (!resetn)
      post_start |-> (m.drained && m.done_cnt == {1'b0, last_idx} + 1'b1);
   endproperty
   a_post_gate: assert property (p_post_gate) else $error("Post processing started early");
   property p_sel;
      @(posedge clk) disable iff (!resetn)
      cap_start |-> (cap_sel == (cfg_shared ? '0 : cur));
   endproperty
   a_sel: assert property (p_sel) else $error("Wrong camera settings selected");
   property p_sel_shared;
      @(posedge clk) disable iff (!resetn)
      (cap_start && cfg_shared) |-> (cap_sel == '0);
   endproperty
   a_sel_shared: assert property (p_sel_shared) else $error("Shared mode used non-first settings");
   property p_timeout;
      @(posedge clk) disable iff (!resetn)
      tmo_hit |=> (seq_ng && !ready && state == mtch_pkg::MTCH_DRAIN);
   endproperty
   a_timeout: assert property (p_timeout) else $error("Timeout did not fail the sequence");
   property p_trig_gate;
      @(posedge clk) disable iff (!resetn)
      trig_acc |-> (ready && $past(trigger, 2) && !$past(trigger, 3));
   endproperty
   a_trig_gate: assert property (p_trig_gate) else $error("Trigger accepted without edge or ready");
endmodule

// file: testbench/mtch_pipe_model.sv
// Model of the pipeline behind the handshake: capture unit, measurement engine
// and post processing. Assumes the start strobes are one-cycle pulses on clk.
`timescale 1ns/1ps
module mtch_pipe_model #(
   parameter int W        = 4,
   parameter int CAP_LAT  = 5,
   parameter int MEAS_LAT = 30
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Capture unit
   input  wire logic         cap_start,
   input  wire logic [W-1:0] cap_sel,
   output logic              cap_done,
   // Measurement engine
   input  wire logic         meas_start,
   input  wire logic [W-1:0] meas_id,
   output logic              meas_done,
   // Post processing
   input  wire logic         post_start,
   output logic              post_done,
   // Observation
   output int                done_cnt,
   output int                outst
);
   // =========================================================
   // Behaviour
   int tick_n;
   int cap_left;
   int due[$];

   // Measurement latency is much longer than capture, so ready timing tells
   // clearly whether the design waited for a measurement or not
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tick_n = 0;
         cap_left = 0;
         due.delete();
         cap_done <= 1'b0;
         meas_done <= 1'b0;
         post_done <= 1'b0;
         done_cnt <= 0;
         outst <= 0;
      end
      else
      begin
         tick_n = tick_n + 1;
         cap_done <= (cap_left == 1);
         if (cap_left > 0)
            cap_left = cap_left - 1;
         if (cap_start === 1'b1)
            cap_left = CAP_LAT;
         post_done <= (post_start === 1'b1);
         meas_done <= 1'b0;
         if (due.size() > 0 && due[0] == tick_n)
         begin
            void'(due.pop_front());
            meas_done <= 1'b1;
            done_cnt <= done_cnt + 1;
         end
         if (meas_start === 1'b1)
            due.push_back(tick_n + MEAS_LAT);
         outst <= due.size();
      end
   end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the multi-trigger capture handshake.
// Assumes mtch_pkg and mtch_top are compiled first; the bench acts as host.
`timescale 1ns/1ps
module tb_top;
   // =========================================================
   // Signals
   logic       clk;
   logic       resetn;
   logic       shared_settings;
   logic       concurrent;
   logic [3:0] num_tasks;
   logic [5:0] timeout_sec;
   logic       trigger;
   logic       ready;
   logic       busy;
   logic       seq_ng;
   logic       cap_start;
   logic [3:0] cap_sel;
   logic       cap_done;
   logic       meas_start;
   logic [3:0] meas_id;
   logic       meas_done;
   logic       post_start;
   logic       post_done;
   int         done_cnt;
   int         outst;
   int         err_total;
   int         checks;
   int         caps;
   int         posts;
   int         post_at;
   int         omax;
   int         meas_n;

   mtch_top #(.TASK_W(4), .CYC_PER_SEC(20)) mtch_top_i (.clk(clk), .resetn(resetn),
      .shared_settings(shared_settings), .concurrent(concurrent), .num_tasks(num_tasks),
      .timeout_sec(timeout_sec), .trigger(trigger), .ready(ready), .busy(busy), .seq_ng(seq_ng),
      .cap_start(cap_start), .cap_sel(cap_sel), .cap_done(cap_done), .meas_start(meas_start),
      .meas_id(meas_id), .meas_done(meas_done), .post_start(post_start), .post_done(post_done));

   mtch_pipe_model mtch_pipe_model_i (.clk(clk), .resetn(resetn), .cap_start(cap_start),
      .cap_sel(cap_sel), .cap_done(cap_done), .meas_start(meas_start), .meas_id(meas_id),
      .meas_done(meas_done), .post_start(post_start), .post_done(post_done),
      .done_cnt(done_cnt), .outst(outst));

   // =========================================================
   // Clock and monitors
   always #50 clk = ~clk;

   always @(posedge clk)
   begin
      #1;
      if (cap_start === 1'b1)
         caps++;
      if (post_start === 1'b1)
      begin
         posts++;
         post_at = done_cnt;
      end
      if (outst > omax)
         omax = outst;
      if (meas_start === 1'b1)
      begin
         check_vec(meas_id, 4'(meas_n));
         meas_n++;
      end
   end

   // =========================================================
   // Helpers
   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic check_bit(input logic act, input logic exp);
      checks++;
      if (act !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got %h expected %h", $time, act, exp);
      end
   endtask

   task automatic check_vec(input logic [3:0] act, input logic [3:0] exp);
      checks++;
      if (act !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got %h expected %h", $time, act, exp);
      end
   endtask

   task automatic check_int(input int act, input int exp);
      checks++;
      if (act != exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got %h expected %h", $time, act, exp);
      end
   endtask

   task automatic summarize();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One host trigger; hold keeps it high past the acknowledge
   task automatic step(input int hold);
      int i;
      for (i = 0; i < 500 && ready !== 1'b1; i++) tick();
      trigger = 1'b1;
      for (i = 0; i < 50 && ready !== 1'b0; i++) tick();
      check_bit(ready, 1'b0);
      check_bit(busy, 1'b1);
      repeat (hold) tick();
      trigger = 1'b0;
      tick();
   endtask

   // =========================================================
   // Scenarios
   task automatic run_seq(input logic s, input logic c, input int n, input int hold);
      int i;
      int k;
      int d0;
      int p0;
      int c0;
      d0 = done_cnt;
      p0 = posts;
      c0 = caps;
      omax = 0;
      meas_n = 0;
      shared_settings = s;
      concurrent = c;
      num_tasks = 4'(n);
      for (k = 0; k < n; k++)
      begin
         step((k == 0) ? hold : 0);
         check_vec(cap_sel, s ? 4'h0 : 4'(k));
         if (k < n - 1 || !s)
         begin
            for (i = 0; i < 500 && ready !== 1'b1; i++) tick();
            if (k == n - 1)
               check_int(done_cnt - d0, n);
            else if (s || c)
               check_int(int'(done_cnt - d0 <= k), 1);
            else
               check_int(int'(done_cnt - d0 >= k + 1), 1);
         end
      end
      for (i = 0; i < 800 && busy !== 1'b0; i++)
      begin
         if (s)
            check_bit(ready, 1'b0);
         tick();
      end
      check_bit(busy, 1'b0);
      check_bit(ready, 1'b1);
      check_int(posts - p0, 1);
      check_int(post_at - d0, n);
      check_int(caps - c0, n);
      if (!c)
         check_int(omax, 1);
   endtask

   task automatic t_timeout();
      int i;
      int p0;
      p0 = posts;
      meas_n = 0;
      shared_settings = 1'b1;
      concurrent = 1'b1;
      num_tasks = 4'h2;
      timeout_sec = 6'h01;
      step(0);
      for (i = 0; i < 500 && ready !== 1'b1; i++) tick();
      repeat (15) tick();
      check_bit(seq_ng, 1'b0);
      for (i = 0; i < 100 && seq_ng !== 1'b1; i++) tick();
      check_bit(seq_ng, 1'b1);
      check_bit(ready, 1'b0);
      for (i = 0; i < 300 && busy !== 1'b0; i++) tick();
      check_bit(ready, 1'b1);
      check_int(posts - p0, 0);
   endtask

   // =========================================================
   // Main sequence
   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      shared_settings = 1'b1;
      concurrent = 1'b1;
      num_tasks = 4'h1;
      timeout_sec = 6'h0A;
      trigger = 1'b0;
      err_total = 0;
      checks = 0;
      caps = 0;
      posts = 0;
      post_at = 0;
      omax = 0;
      meas_n = 0;
      repeat (5) tick();
      check_bit(ready, 1'b1);
      check_bit(busy, 1'b0);
      resetn = 1'b1;
      tick();
      run_seq(1'b1, 1'b1, 3, 0);
      run_seq(1'b1, 1'b0, 3, 0);
      run_seq(1'b0, 1'b1, 3, 0);
      run_seq(1'b0, 1'b0, 3, 0);
      run_seq(1'b1, 1'b1, 1, 0);
      // Trigger still high when ready returns must not start a second capture
      run_seq(1'b0, 1'b0, 2, 60);
      t_timeout();
      summarize();
   end

   // Sequences take well under 5000 cycles in all
   initial
   begin
      #(30000 * 100);
      err_total++;
      summarize();
   end
endmodule
